/* File: inc/amw_cfg.svh */
// Purpose: Constants for the AXI4 memory write path (both ends)
// Assumes: One clock at 250 MHz
// Notes: Burst type and response codes follow the published AXI4 encoding
`ifndef AMW_CFG_SVH
`define AMW_CFG_SVH
`define AMW_BURST_FIXED 2'h0
`define AMW_BURST_INCR 2'h1
`define AMW_BURST_WRAP 2'h2
`define AMW_RESP_OKAY 2'h0
`define AMW_ADDR_W 32
`define AMW_LEN_W 8
`define AMW_SIZE_W 3
`define AMW_ID_MAX 16
`define AMW_ADDR_RST 32'h0000_0000
`endif

/* File: inc/amw_if.sv */
// Purpose: AXI4 write channels between master and slave
// Assumes: Single clock, active-low reset driven by the bench
// Notes: No clocking block; data and ID widths are parameters, address and length widths are fixed
`timescale 1ns/1ps
interface amw_if #(
  parameter int DATA_W = 32,
  parameter int ID_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn
);
  logic [ID_W-1:0] awid;
  logic [31:0] awaddr;
  logic [7:0] awlen;
  logic [2:0] awsize;
  logic [1:0] awburst;
  logic awvalid;
  logic awready;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W/8-1:0] wstrb;
  logic wlast;
  logic wvalid;
  logic wready;
  logic [ID_W-1:0] bid;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  modport slave (
    input aclk, aresetn, awid, awaddr, awlen, awsize, awburst, awvalid,
    input wdata, wstrb, wlast, wvalid, bready,
    output awready, wready, bid, bresp, bvalid
  );
  modport master (
    input aclk, aresetn, awready, wready, bid, bresp, bvalid,
    output awid, awaddr, awlen, awsize, awburst, awvalid,
    output wdata, wstrb, wlast, wvalid, bready
  );
endinterface

/* File: inc/amw_pkg.sv */
// Purpose: Types shared by the master and slave ends
// Assumes: amw_cfg.svh holds the numeric constants
// Notes: Configuration selects the memory or peripheral flavour
package amw_pkg;
  typedef enum logic {
    AMW_CFG_MEMORY = 1'b0,
    AMW_CFG_PERIPH = 1'b1
  } amw_cfg_e;
  typedef enum logic [1:0] {
    AMW_S_IDLE = 2'b00,
    AMW_S_DATA = 2'b01,
    AMW_S_RESP = 2'b10
  } amw_state_e;
endpackage

/* File: logic/amw_master.sv */
// Purpose: AXI4 write master issuing one burst per user command
// Assumes: Slave follows the AXI4 handshake
// Notes: Beat data is a counter seeded from the command
`timescale 1ns/1ps
`include "amw_cfg.svh"
module amw_master
  import amw_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ID_W = 4,
  parameter bit EXPECT_RESP = 1'b1
) (
  input wire logic i_clock,            // Interface clock
  input wire logic i_rst,              // Async reset, active high
  amw_if.master bus,                   // AXI4 write channels
  input wire logic i_start,            // Command pulse
  input wire logic [31:0] i_addr,      // First beat address
  input wire logic [7:0] i_len,        // Beats minus one
  input wire logic [2:0] i_size,       // Bytes per beat, log2
  input wire logic [1:0] i_burst,      // Burst type
  input wire logic [ID_W-1:0] i_id,    // Transaction ID
  input wire logic [DATA_W-1:0] i_data,// First beat data
  input wire logic [DATA_W/8-1:0] i_strb, // Strobes for every beat
  output logic o_ready,                // Can take a command
  output logic o_done,                 // Burst finished, one cycle
  output logic [ID_W-1:0] o_bid        // Returned ID
);
  amw_state_e state;
  logic aw_pend;
  logic [7:0] left;
  logic [ID_W-1:0] id_q;

  assign o_ready = (state == AMW_S_IDLE);
  wire aw_fire = bus.awvalid & bus.awready;
  wire w_fire = bus.wvalid & bus.wready;
  assign bus.awvalid = aw_pend; // [RULE_10]
  assign bus.wvalid = (state == AMW_S_DATA); // [RULE_16]
  assign bus.wlast = bus.wvalid && (left == 8'h00); // [RULE_15]
  assign bus.bready = (state == AMW_S_RESP); // [RULE_21]
  assign bus.awid = id_q;

  always_ff @(posedge i_clock or posedge i_rst) begin // [RULE_01]
    if (i_rst) begin
      state <= AMW_S_IDLE;
      aw_pend <= 1'b0;
      left <= 8'h00;
      id_q <= '0;
      bus.awaddr <= `AMW_ADDR_RST;
      bus.awlen <= 8'h00;
      bus.awsize <= 3'h0;
      bus.awburst <= `AMW_BURST_INCR;
      bus.wdata <= '0;
      bus.wstrb <= '0;
      o_done <= 1'b0;
      o_bid <= '0;
    end else begin
      o_done <= 1'b0;
      if (aw_fire) begin
        aw_pend <= 1'b0;
      end
      unique case (state)
        AMW_S_IDLE: begin
          if (i_start) begin
            aw_pend <= 1'b1;
            id_q <= i_id;
            bus.awaddr <= i_addr;
            bus.awlen <= i_len;
            bus.awsize <= i_size; // [RULE_06]
            bus.awburst <= i_burst;
            bus.wdata <= i_data;
            bus.wstrb <= i_strb;
            left <= i_len;
            state <= AMW_S_DATA;
          end
        end
        AMW_S_DATA: begin
          if (w_fire) begin
            bus.wdata <= bus.wdata + DATA_W'(1);
            left <= left - 8'h01;
            if (left == 8'h00) begin
              state <= EXPECT_RESP ? AMW_S_RESP : AMW_S_IDLE;
              o_done <= !EXPECT_RESP;
            end
          end
        end
        AMW_S_RESP: begin
          if (bus.bvalid) begin
            o_bid <= bus.bid;
            o_done <= 1'b1;
            state <= AMW_S_IDLE;
          end
        end
        default: state <= AMW_S_IDLE;
      endcase
    end
  end
endmodule

/* File: logic/amw_slave.sv */
// Purpose: AXI4 write slave in front of a flip-flop memory
// Assumes: Master keeps its side of the handshakes
// Notes: A two-entry buffer sits between the W channel and memory
//
// Contract
// RULE_01: Everything sampled on rising interface clock only.
// RULE_02: Reset active when low.
// RULE_03: Address ID only in memory configuration.
// RULE_04: Address gives first beat; rest derived.
// RULE_05: Accept exactly burst length beats.
// RULE_06: Master keeps size within data width.
// RULE_07: Peripheral configuration ignores burst size.
// RULE_08: Memory configuration supports incrementing and wrapping.
// RULE_09: Peripheral configuration forces incrementing bursts.
// RULE_10: Master holds address stable until ready.
// RULE_11: Address ready only when address acceptable.
// RULE_12: Memory data width 32 to 256.
// RULE_13: Peripheral data width 8 to 256.
// RULE_14: One strobe per byte gates lane writes.
// RULE_15: Master marks last beat with last.
// RULE_16: Master write valid marks valid data.
// RULE_17: Write ready only when beat acceptable.
// RULE_18: Response ID equals accepted address ID.
// RULE_19: Response ID 1 to 16 bits, memory only.
// RULE_20: OKAY response, memory configuration with IDs only.
// RULE_21: Response completes when valid and ready high.
// RULE_22: Transfer only when valid and ready high.
// RULE_23: Increment by size; wrap at len times size.
`timescale 1ns/1ps
`include "amw_cfg.svh"
module amw_slave
  import amw_pkg::*;
#(
  parameter amw_cfg_e CFG = AMW_CFG_MEMORY,
  parameter bit USE_ID = 1'b1,
  parameter int DATA_W = 32,
  parameter int ID_W = 4,
  parameter int DEPTH = 1024
) (
  input wire logic i_clock,        // Interface clock
  input wire logic i_rst,          // Async reset, active high
  amw_if.slave bus,                // AXI4 write channels
  input wire logic [$clog2(DEPTH)-1:0] i_rd_index, // Memory peek index
  output logic [DATA_W-1:0] o_rd_data, // Word at peek index
  output logic o_busy              // Burst in progress
);
  localparam int SB = DATA_W / 8;
  localparam int AW = $clog2(DEPTH);
  localparam int LB = $clog2(SB);
  localparam bit HAS_RESP = (CFG == AMW_CFG_MEMORY) && USE_ID;

  initial begin
    if (CFG == AMW_CFG_MEMORY &&
        !(DATA_W inside {32, 64, 128, 256})) begin
      $error("bad memory data width"); // [RULE_12]
    end
    if (CFG == AMW_CFG_PERIPH &&
        !(DATA_W inside {8, 16, 32, 64, 128, 256})) begin
      $error("bad peripheral data width"); // [RULE_13]
    end
    if (ID_W < 1 || ID_W > `AMW_ID_MAX) begin
      $error("bad id width"); // [RULE_19]
    end
  end

  // Reset combines the local port and the bus reset (low = reset)
  wire rst_any = i_rst | ~bus.aresetn; // [RULE_02]

  amw_state_e state;
  logic [31:0] addr;
  // One bit wider than the length field so a 256-beat burst counts
  logic [8:0] beats_left;
  logic [2:0] size;
  logic [1:0] burst;
  logic [ID_W-1:0] id;
  logic [DATA_W-1:0] mem [DEPTH];

  // Peripheral flavour has no size or type pins: use full width, INCR
  wire [2:0] eff_size = (CFG == AMW_CFG_PERIPH) ?
    3'(LB) : bus.awsize; // [RULE_07]
  wire [1:0] eff_burst = (CFG == AMW_CFG_PERIPH) ?
    `AMW_BURST_INCR : bus.awburst; // [RULE_08] [RULE_09]
  wire [ID_W-1:0] eff_id = HAS_RESP ? bus.awid : '0; // [RULE_03]

  assign bus.awready = (state == AMW_S_IDLE); // [RULE_11]
  wire aw_fire = bus.awvalid & bus.awready; // [RULE_22]

  // Two-entry skid buffer on the data path
  logic [DATA_W+SB-1:0] buf_q [2];
  logic [31:0] buf_a [2];
  logic [1:0] buf_cnt;
  logic buf_wp;
  logic buf_rp;
  logic beat_ok;
  assign beat_ok = (state == AMW_S_DATA) && (beats_left != 9'h000);
  assign bus.wready = beat_ok && (buf_cnt != 2'd2); // [RULE_17]
  wire w_fire = bus.wvalid & bus.wready; // [RULE_22]
  wire drain = (buf_cnt != 2'd0);
  wire last_beat = w_fire && (beats_left == 9'h001); // [RULE_05]

  function automatic logic [31:0] next_beat_addr(
    input logic [31:0] a, input logic [2:0] sz, input logic [1:0] bt,
    input logic [7:0] len);
    logic [31:0] step;
    logic [31:0] span;
    logic [31:0] base;
    step = 32'h0000_0001 << sz;
    span = (32'({24'h0, len}) + 32'h0000_0001) << sz;
    base = a & ~(span - 32'h0000_0001);
    if (bt == `AMW_BURST_WRAP) begin
      next_beat_addr = base | ((a + step) & (span - 32'h0000_0001));
    end else begin
      next_beat_addr = (a & ~(step - 32'h0000_0001)) + step;
    end
  endfunction

  logic [7:0] len_q;
  wire [31:0] next_addr =
    next_beat_addr(addr, size, burst, len_q); // [RULE_23]

  always_ff @(posedge i_clock or posedge rst_any) begin // [RULE_01]
    if (rst_any) begin
      state <= AMW_S_IDLE;
      addr <= `AMW_ADDR_RST;
      beats_left <= 9'h000;
      len_q <= 8'h00;
      size <= 3'h0;
      burst <= 2'h0;
      id <= '0;
    end else begin
      unique case (state)
        AMW_S_IDLE: begin
          if (aw_fire) begin // [RULE_04]
            addr <= bus.awaddr;
            len_q <= bus.awlen;
            beats_left <= 9'(bus.awlen) + 9'h001;
            size <= eff_size;
            burst <= eff_burst;
            id <= eff_id; // [RULE_18]
            state <= AMW_S_DATA;
          end
        end
        AMW_S_DATA: begin
          if (w_fire) begin
            beats_left <= beats_left - 9'h001;
            addr <= next_addr;
          end
          if (last_beat) begin
            state <= HAS_RESP ? AMW_S_RESP : AMW_S_IDLE; // [RULE_20]
          end
        end
        AMW_S_RESP: begin
          if (bus.bvalid && bus.bready && !drain) begin // [RULE_21]
            state <= AMW_S_IDLE;
          end
        end
        default: state <= AMW_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge rst_any) begin
    if (rst_any) begin
      buf_cnt <= 2'd0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
    end else begin
      buf_cnt <= buf_cnt + 2'(w_fire) - 2'(drain);
      if (w_fire) begin
        buf_wp <= ~buf_wp;
      end
      if (drain) begin
        buf_rp <= ~buf_rp;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (w_fire) begin
      buf_q[buf_wp] <= {bus.wstrb, bus.wdata};
      buf_a[buf_wp] <= addr;
    end
  end

  // Memory write gated per byte lane
  wire [DATA_W-1:0] d_out = buf_q[buf_rp][DATA_W-1:0];
  wire [SB-1:0] s_out = buf_q[buf_rp][DATA_W+SB-1:DATA_W];
  wire [AW-1:0] m_idx = AW'(buf_a[buf_rp] >> LB);
  wire [DATA_W-1:0] next_word;
  genvar g;
  generate
    for (g = 0; g < SB; g++) begin : g_lane
      // Unstrobed lanes keep the old byte; one process owns the memory
      assign next_word[8*g +: 8] = s_out[g] ?
        d_out[8*g +: 8] : mem[m_idx][8*g +: 8]; // [RULE_14]
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (drain) begin
      mem[m_idx] <= next_word;
    end
  end

  // Response waits until buffered beats reach memory
  assign bus.bvalid = HAS_RESP && (state == AMW_S_RESP) && !drain; // [RULE_21]
  assign bus.bresp = `AMW_RESP_OKAY; // [RULE_20]
  assign bus.bid = id; // [RULE_18]

  always_ff @(posedge i_clock or posedge rst_any) begin
    if (rst_any) begin
      o_rd_data <= '0;
      o_busy <= 1'b0;
    end else begin
      o_rd_data <= mem[i_rd_index];
      o_busy <= (state != AMW_S_IDLE) | drain;
    end
  end
endmodule

/* File: tb/amw_asserts.sv */
// Purpose: Handshake checks on the write channels
// Assumes: One burst at a time, as the master issues them
// Notes: Beat count is kept in helper logic
`timescale 1ns/1ps
`include "amw_cfg.svh"
module amw_asserts #(
  parameter int ID_W = 4
) (
  input wire logic aclk,            // Clock
  input wire logic aresetn,         // Reset, low
  input wire logic [ID_W-1:0] awid, // Addr ID
  input wire logic [31:0] awaddr,   // Addr
  input wire logic [7:0] awlen,     // Length
  input wire logic awvalid,         // Addr valid
  input wire logic awready,         // Addr ready
  input wire logic wlast,           // Last beat
  input wire logic wvalid,          // Data valid
  input wire logic wready,          // Data ready
  input wire logic [ID_W-1:0] bid,  // Resp ID
  input wire logic [1:0] bresp,     // Resp code
  input wire logic bvalid,          // Resp valid
  input wire logic bready           // Resp ready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic busy;
  logic dph;
  logic [7:0] len_q;
  logic [7:0] cnt;
  logic [ID_W-1:0] id_q;
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  wire b_hs = bvalid && bready;
  wire at_end = cnt == len_q;
  always_ff @(posedge aclk or negedge aresetn) begin
    if (!aresetn) begin
      busy <= 1'b0;
      dph <= 1'b0;
      cnt <= '0;
    end else begin
      busy <= aw_hs || (busy && !b_hs);
      dph <= aw_hs || (dph && !(w_hs && at_end));
      cnt <= aw_hs ? 8'h00 : cnt + 8'(w_hs);
    end
  end
  always_ff @(posedge aclk) begin
    if (aw_hs) begin
      len_q <= awlen;
      id_q <= awid;
    end
  end
  AST_AW_HOLD: assert property (awvalid && !awready |=> awvalid &&
    $stable(awaddr) && $stable(awlen)) else $error("address moved");
  AST_AW_BUSY: assert property (busy |-> !awready)
    else $error("address taken mid burst");
  AST_W_IDLE: assert property (!dph && !awvalid |-> !wready)
    else $error("data ready outside burst");
  AST_BEATS: assert property (w_hs |-> wlast == at_end)
    else $error("beat count off");
  AST_W_HOLD: assert property (wvalid && !wready |=>
    wvalid && $stable(wlast)) else $error("data beat dropped");
  AST_B_OKAY: assert property (bvalid |-> bresp == `AMW_RESP_OKAY)
    else $error("bad response code");
  AST_B_ID: assert property (bvalid |-> bid == id_q)
    else $error("response id differs");
  AST_B_HOLD: assert property (bvalid && !bready |=>
    bvalid && $stable(bid)) else $error("response dropped");
  AST_B_TIME: assert property (w_hs && wlast |-> ##[1:3] bvalid)
    else $error("response late");
  AST_B_ONLY: assert property (bvalid |-> busy && !dph)
    else $error("response without burst");
  cover property (aw_hs && awlen == 8'hFF);
  cover property (wvalid && !wready);
  cover property (b_hs);
endmodule

/* File: tb/axi4_memory_write_slave_test.sv */
// Purpose: Random and corner bursts from master end into slave memory
// Assumes: Master beat k carries first data plus k; size up to full width
// Notes: Whole memory is reread after each burst to catch stray writes
`timescale 1ns/1ps
`include "amw_cfg.svh"
module axi4_memory_write_slave_test;
  import amw_pkg::*;
  localparam int DEPTH = 64;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic [31:0] i_addr = '0;
  logic [7:0] i_len = '0;
  logic [1:0] i_burst = '0;
  logic [2:0] i_size = 3'h2;
  logic [3:0] i_id = '0;
  logic [31:0] i_data = '0;
  logic [3:0] i_strb = '0;
  logic [5:0] rd_idx = '0;
  logic [31:0] rd_data;
  logic busy;
  logic o_ready;
  logic o_done;
  logic [3:0] o_bid;
  logic [31:0] mem [DEPTH];
  logic [1:0] bt;
  int error_cnt = 0;
  int checks = 0;
  always #2 i_clock = ~i_clock;
  amw_if #(.DATA_W(32), .ID_W(4)) bus_if (.aclk(i_clock), .aresetn(~i_rst));
  amw_master amw_master_inst (.i_clock(i_clock), .i_rst(i_rst),
    .bus(bus_if.master), .i_start(i_start), .i_addr(i_addr), .i_len(i_len),
    .i_size(i_size), .i_burst(i_burst), .i_id(i_id), .i_data(i_data),
    .i_strb(i_strb), .o_ready(o_ready), .o_done(o_done), .o_bid(o_bid));
  amw_slave #(.DEPTH(DEPTH)) amw_slave_inst (.i_clock(i_clock),
    .i_rst(i_rst), .bus(bus_if.slave), .i_rd_index(rd_idx),
    .o_rd_data(rd_data), .o_busy(busy));
  amw_asserts #(.ID_W(4)) amw_asserts_inst (.aclk(i_clock),
    .aresetn(bus_if.aresetn), .awid(bus_if.awid), .awaddr(bus_if.awaddr),
    .awlen(bus_if.awlen), .awvalid(bus_if.awvalid),
    .awready(bus_if.awready), .wlast(bus_if.wlast),
    .wvalid(bus_if.wvalid), .wready(bus_if.wready), .bid(bus_if.bid),
    .bresp(bus_if.bresp), .bvalid(bus_if.bvalid), .bready(bus_if.bready));
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_id(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: id %h not %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Word index of beat k; fixed bursts step like incrementing ones
  function automatic int widx(logic [31:0] a, int k, logic [7:0] len,
      logic [2:0] sz);
    int st = 1 << sz;
    int sp = (len + 1) * st;
    int b = a + k * st;
    if (bt == `AMW_BURST_WRAP)
      b = a - a % sp + (a % sp + k * st) % sp;
    return (b / 4) % DEPTH;
  endfunction
  task automatic burst(input logic [31:0] a, input logic [7:0] len,
      input logic [31:0] d, input logic [3:0] s, input logic [3:0] id,
      input logic [2:0] sz);
    int t = 0;
    logic [31:0] v;
    while (o_ready !== 1'b1 && t < 300) begin
      @(posedge i_clock);
      #1 t++;
    end
    {i_start, i_addr, i_len, i_burst, i_data, i_strb, i_id, i_size} =
      {1'b1, a, len, bt, d, s, id, sz};
    @(posedge i_clock);
    #1 i_start = 1'b0;
    t = 0;
    while (o_done !== 1'b1 && t < 1000) begin
      @(posedge i_clock);
      #1 t++;
    end
    if (o_done !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: burst did not finish", $time);
    end
    cmp_id(o_bid, id);
    for (int k = 0; k <= len; k++) begin
      v = d + k;
      for (int b = 0; b < 4; b++)
        if (s[b]) mem[widx(a, k, len, sz)][8*b+:8] = v[8*b+:8];
    end
    @(posedge i_clock);
    #1 cmp_id({3'h0, busy}, 4'h0);
    for (int i = 0; i < DEPTH; i++) begin
      rd_idx = 6'(i);
      @(posedge i_clock);
      #1 cmp_word(rd_data, mem[i]);
    end
  endtask
  initial begin
    #(4 * 60000);
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(750));
    repeat (2) @(posedge i_clock);
    #1 i_rst = 1'b0;
    bt = `AMW_BURST_INCR;
    burst(32'h0, 8'hFF, $urandom, 4'hF, 4'h1, 3'h2);
    bt = `AMW_BURST_WRAP;
    burst(32'h0000_0078, 8'h0F, $urandom, 4'hF, 4'h2, 3'h2);
    bt = `AMW_BURST_FIXED;
    burst(32'h0000_0010, 8'h03, $urandom, 4'h0, 4'h3, 3'h2);
    for (int n = 0; n < 30; n++) begin
      bt = 2'($urandom_range(0, 2));
      burst({24'h0, 6'($urandom_range(0, 63)), 2'b00},
        (bt == `AMW_BURST_WRAP) ? 8'((1 << $urandom_range(1, 4)) - 1) :
        8'($urandom_range(0, 15)), $urandom, 4'($urandom), 4'($urandom),
        3'($urandom_range(0, 2)));
    end
    finish_test();
  end
endmodule
